// ---- shared/cesq_map.vh ----
// register map, field positions, reset values and timing figures of the converter
// enable sequencer; included by the top design file of the block only, definitions only
`ifndef CESQ_MAP_VH
`define CESQ_MAP_VH

// register offsets (byte addresses on the register port)
`define CESQ_REG_RSVD_A 8'h0c
`define CESQ_REG_RSVD_B 8'h0d
`define CESQ_REG_ENABLE 8'h0e
`define CESQ_REG_CONFIG 8'h0f

// reset values
`define CESQ_RST_RSVD_A 8'h10
`define CESQ_RST_RSVD_B 8'h08
`define CESQ_RST_ENABLE 8'ha2
`define CESQ_RST_CONFIG 8'he8

// converter_enable_control fields
`define CESQ_EN_PERMIT 7
`define CESQ_EN_BYPASS 6
`define CESQ_EN_SOFTSTART 5
`define CESQ_EN_RSVD 4
`define CESQ_EN_OFFDLY_HI 3
`define CESQ_EN_OFFDLY_LO 2
`define CESQ_EN_POLARITY 1
`define CESQ_EN_LOADOFF 0

// converter_config_control fields
`define CESQ_CF_UV_HI 7
`define CESQ_CF_UV_LO 5
`define CESQ_CF_STATUS 4
`define CESQ_CF_CABLE_HI 3
`define CESQ_CF_CABLE_LO 2
`define CESQ_CF_DELAY_HI 1
`define CESQ_CF_DELAY_LO 0

// analog selections, in millivolts per code step
`define CESQ_UV_STEP_MV 200
`define CESQ_CABLE_STEP_MV 100

// clock rate and the printed times
`define CESQ_CLK_MHZ 10
`define CESQ_CLK_KHZ 10000
`define CESQ_SS_SHORT_US 1500
`define CESQ_SS_LONG_US 5000
`define CESQ_ON_DLY1_MS 200
`define CESQ_ON_DLY2_MS 500
`define CESQ_ON_DLY3_MS 1000
`define CESQ_OFF_DLY1_MS 10000
`define CESQ_OFF_DLY2_MS 20000
`define CESQ_OFF_DLY3_MS 30000

`endif

// ---- src/cesq_sync.v ----
// two flip-flop synchroniser for levels arriving from pins
// assumes each bit is a slow level; a pulse shorter than one clock may be lost
`timescale 1ns/1ps
module cesq_sync #(
  parameter WIDTH = 1
) (
  input wire i_clock,              // system clock
  input wire i_resetn,             // async reset, active low
  input wire [WIDTH-1:0] i_async,  // level from outside the clock domain
  output wire [WIDTH-1:0] o_sync   // synchronised level
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage is read only by the second stage
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ---- src/cesq_timer.v ----
// interval timer: counts enabled cycles up to a limit and then holds done
// assumes the limit stays steady while counting; a limit of zero is done at once
`timescale 1ns/1ps
module cesq_timer #(
  parameter WIDTH = 32
) (
  input wire i_clock,             // system clock
  input wire i_resetn,            // async reset, active low
  input wire i_clear,             // restart from zero, wins over counting
  input wire i_count,             // count this cycle
  input wire [WIDTH-1:0] i_limit, // cycles to reach done
  output wire o_done              // limit reached, level
);
  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  assign o_done = (count_q >= i_limit);

  // saturate at the limit so a long wait never wraps back to not done
  always @* begin
    count_d = count_q;
    if (i_clear) begin
      count_d = {WIDTH{1'b0}};
    end else if (i_count && !o_done) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end
endmodule

// ---- src/cesq_top.v ----
// converter enable sequencer: control registers, enable qualification, turn-on
// delay, soft-start, light-load latch-off and the open-drain run status pin
// assumes a register port driven by the serial bus front end on the same clock,
// and pin or comparator levels that may change at any time
`timescale 1ns/1ps
`include "cesq_map.vh"

// How it works
// - a clear master permit bit keeps the converter off whatever the pin or bypass say.
// - with permit set the pin or the register path enables, only while standby-off is low.
// - with pin bypass set the pin is ignored and only the permit bit and standby-off decide.
// - soft-start lasts 1.5 ms with its select bit clear and 5 ms with it set.
// - the light-load delay code 00 disables it and 01, 10, 11 give 10 s, 20 s, 30 s.
// - an armed light load outlasting the delay turns off and latches until re-enabled.
// - the enable pin is active low with polarity clear and active high with it set.
// - the undervolt code lowers the threshold by 0.2 V per step, down to 1.4 V at 111.
// - with status drive set the pin is pulled low while running and free on fault or UV.
// - the cable-drop code 00 disables it and 01, 10, 11 give 100, 200, 300 mV.
// - after an enable the start waits 0 ms, 200 ms, 500 ms or 1 s by the delay code.
module cesq_top #(
  parameter [31:0] SS_SHORT_CYC = `CESQ_SS_SHORT_US * `CESQ_CLK_MHZ,
  parameter [31:0] SS_LONG_CYC = `CESQ_SS_LONG_US * `CESQ_CLK_MHZ,
  parameter [31:0] ON_DLY1_CYC = `CESQ_ON_DLY1_MS * `CESQ_CLK_KHZ,
  parameter [31:0] ON_DLY2_CYC = `CESQ_ON_DLY2_MS * `CESQ_CLK_KHZ,
  parameter [31:0] ON_DLY3_CYC = `CESQ_ON_DLY3_MS * `CESQ_CLK_KHZ,
  parameter [31:0] OFF_DLY1_CYC = `CESQ_OFF_DLY1_MS * `CESQ_CLK_KHZ,
  parameter [31:0] OFF_DLY2_CYC = `CESQ_OFF_DLY2_MS * `CESQ_CLK_KHZ,
  parameter [31:0] OFF_DLY3_CYC = `CESQ_OFF_DLY3_MS * `CESQ_CLK_KHZ
) (
  input wire i_clock,                // 10 MHz system clock
  input wire i_resetn,               // async reset, active low
  input wire [7:0] i_reg_addr,       // register byte address
  input wire [7:0] i_reg_wdata,      // register write data
  input wire i_reg_write,            // write strobe, one cycle
  input wire i_reg_read,             // read strobe, one cycle
  output reg [7:0] o_reg_rdata,      // read data, valid the cycle after the read
  input wire i_enable_pin,           // external enable pin, asynchronous
  input wire i_light_load,           // light-load comparator, asynchronous
  input wire i_output_fault,         // output fault flag, asynchronous
  input wire i_input_undervolt,      // input undervoltage flag, asynchronous
  input wire i_standby_off_state,    // standby-off mode bit, same clock
  output reg o_converter_run,        // converter switching (soft-start or run)
  output reg o_softstart_active,     // soft-start ramp in progress
  output reg o_softstart_long,       // selected ramp is the long one
  output reg o_lightload_latched,    // latched off by light load
  output reg [10:0] o_undervolt_offset_mv, // threshold offset below base level
  output reg [8:0] o_cable_comp_mv,  // cable-drop compensation amount
  output wire o_status_out,          // status pin output value, always low
  output reg o_status_oe             // status pin pull-down enable
);
  // sequencer states
  // binary codes; an unused code falls back to off through the default branch
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_SOFT = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_LATCH = 3'h4;

  reg [7:0] rsvd_a_q;
  reg [7:0] rsvd_b_q;
  reg [7:0] enable_q;
  reg [7:0] config_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] rdata_d;
  reg [31:0] on_limit;
  reg [31:0] ss_limit;
  reg [31:0] off_limit;
  wire [3:0] pins_sync;
  wire pin_level;
  wire light_load;
  wire out_fault;
  wire in_uv;
  wire pin_active;
  wire enable_req;
  wire off_armed;
  wire on_done;
  wire ss_done;
  wire off_done;
  wire running_d;

  // all four outside levels pass two flops before any logic looks at them
  // so a pin change is seen two clocks late, far below any delay the sequencer counts
  cesq_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async({i_input_undervolt, i_output_fault, i_light_load, i_enable_pin}),
    .o_sync(pins_sync)
  );

  assign pin_level = pins_sync[0];
  assign light_load = pins_sync[1];
  assign out_fault = pins_sync[2];
  assign in_uv = pins_sync[3];

  // pin polarity select
  assign pin_active = enable_q[`CESQ_EN_POLARITY] ? pin_level : ~pin_level;

  // permit gates everything; bypass replaces the pin; standby-off vetoes
  // standby-off comes from logic on this clock, so it needs no synchroniser
  assign enable_req = enable_q[`CESQ_EN_PERMIT]
    && !i_standby_off_state
    && (enable_q[`CESQ_EN_BYPASS] || pin_active);

  // light-load shutoff needs both the arm bit and a nonzero delay code
  assign off_armed = enable_q[`CESQ_EN_LOADOFF]
    && (enable_q[`CESQ_EN_OFFDLY_HI:`CESQ_EN_OFFDLY_LO] != 2'b00);

  // turn-on delay selection
  always @* begin
    case (config_q[`CESQ_CF_DELAY_HI:`CESQ_CF_DELAY_LO])
      2'b00: on_limit = 32'h0000_0000;
      2'b01: on_limit = ON_DLY1_CYC;
      2'b10: on_limit = ON_DLY2_CYC;
      default: on_limit = ON_DLY3_CYC;
    endcase
  end

  // soft-start length selection
  always @* begin
    if (enable_q[`CESQ_EN_SOFTSTART]) begin
      ss_limit = SS_LONG_CYC;
    end else begin
      ss_limit = SS_SHORT_CYC;
    end
  end

  // light-load delay selection; code 00 is never used since it disarms
  always @* begin
    case (enable_q[`CESQ_EN_OFFDLY_HI:`CESQ_EN_OFFDLY_LO])
      2'b01: off_limit = OFF_DLY1_CYC;
      2'b10: off_limit = OFF_DLY2_CYC;
      2'b11: off_limit = OFF_DLY3_CYC;
      default: off_limit = 32'hffff_ffff;
    endcase
  end

  // turn-on delay counts only while waiting in the delay state
  // the delay state lasts one clock more than the count, so code 00 still costs a clock
  cesq_timer #(
    .WIDTH(32)
  ) u_on_timer (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clear(state_q != ST_DELAY),
    .i_count(state_q == ST_DELAY),
    .i_limit(on_limit),
    .o_done(on_done)
  );

  // soft-start ramp timer
  // as with the delay, the ramp holds one clock beyond its count
  cesq_timer #(
    .WIDTH(32)
  ) u_ss_timer (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clear(state_q != ST_SOFT),
    .i_count(state_q == ST_SOFT),
    .i_limit(ss_limit),
    .o_done(ss_done)
  );

  // light-load timer restarts whenever the load climbs back up
  // a single clock above the light-load level restarts it; a noisy comparator therefore
  // delays the latch-off rather than causing a false one, which is the safer failure
  cesq_timer #(
    .WIDTH(32)
  ) u_off_timer (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clear((state_q != ST_RUN) || !light_load || !off_armed),
    .i_count(light_load),
    .i_limit(off_limit),
    .o_done(off_done)
  );

  // sequencer; dropping the request from any state returns to off, which is
  // also the only way out of the latched state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (enable_req) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!enable_req) begin
          state_d = ST_OFF;
        end else if (on_done) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (!enable_req) begin
          state_d = ST_OFF;
        end else if (ss_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_req) begin
          state_d = ST_OFF;
        end else if (off_armed && off_done) begin
          state_d = ST_LATCH;
        end
      end
      ST_LATCH: begin
        if (!enable_req) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs follow the next state so they line up with state_q
  assign running_d = (state_d == ST_SOFT) || (state_d == ST_RUN);

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_converter_run <= 1'b0;
      o_softstart_active <= 1'b0;
      o_lightload_latched <= 1'b0;
      o_status_oe <= 1'b0;
    end else begin
      o_converter_run <= running_d;
      o_softstart_active <= (state_d == ST_SOFT);
      o_lightload_latched <= (state_d == ST_LATCH);
      o_status_oe <= config_q[`CESQ_CF_STATUS] && running_d
        && !out_fault && !in_uv;
    end
  end

  // open drain: the pin is only ever pulled low or released
  // fault and undervolt only release the pin; they do not stop the sequencer
  assign o_status_out = 1'b0;

  // analog selections decoded to millivolts for the regulation side
  // registered so the regulation side never sees a half-written code
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_undervolt_offset_mv <= 11'h000;
      o_cable_comp_mv <= 9'h000;
      o_softstart_long <= 1'b0;
    end else begin
      o_undervolt_offset_mv <= config_q[`CESQ_CF_UV_HI:`CESQ_CF_UV_LO]
        * 11'd`CESQ_UV_STEP_MV;
      o_cable_comp_mv <= config_q[`CESQ_CF_CABLE_HI:`CESQ_CF_CABLE_LO]
        * 9'd`CESQ_CABLE_STEP_MV;
      o_softstart_long <= enable_q[`CESQ_EN_SOFTSTART];
    end
  end

  // register writes; unmapped offsets are ignored. reserved contents are
  // stored as written since software is trusted to leave them alone
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rsvd_a_q <= `CESQ_RST_RSVD_A;
      rsvd_b_q <= `CESQ_RST_RSVD_B;
      enable_q <= `CESQ_RST_ENABLE;
      config_q <= `CESQ_RST_CONFIG;
    end else if (i_reg_write) begin
      case (i_reg_addr)
        `CESQ_REG_RSVD_A: rsvd_a_q <= i_reg_wdata;
        `CESQ_REG_RSVD_B: rsvd_b_q <= i_reg_wdata;
        `CESQ_REG_ENABLE: enable_q <= i_reg_wdata;
        `CESQ_REG_CONFIG: config_q <= i_reg_wdata;
        default: rsvd_a_q <= rsvd_a_q;
      endcase
    end
  end

  // read mux; unmapped offsets answer zero
  // a write and a read in one cycle return the contents from before the write
  always @* begin
    case (i_reg_addr)
      `CESQ_REG_RSVD_A: rdata_d = rsvd_a_q;
      `CESQ_REG_RSVD_B: rdata_d = rsvd_b_q;
      `CESQ_REG_ENABLE: rdata_d = enable_q;
      `CESQ_REG_CONFIG: rdata_d = config_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // read data is held until the next read strobe
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_read) begin
      o_reg_rdata <= rdata_d;
    end
  end
endmodule

// ---- tb/cesq_host.sv ----
// host side model: byte register port master and the pin or comparator levels
// assumes the block samples strobes on the rising edge; all changes are made on the falling edge
`timescale 1ns/1ps
module cesq_host (
  input wire i_clock, // system clock
  input wire [7:0] i_rdata, // read data from the block
  output logic [7:0] o_addr, // register address
  output logic [7:0] o_wdata, // write data
  output logic o_write, // write strobe
  output logic o_read, // read strobe
  output logic o_pin, // enable pin level
  output logic o_light, // light-load comparator
  output logic o_fault, // output fault flag
  output logic o_uv, // input undervoltage flag
  output logic o_standby // standby-off mode bit
);
  // everything idle from time zero
  initial begin
    {o_addr, o_wdata, o_write, o_read} = 18'h0;
    {o_standby, o_uv, o_fault, o_light, o_pin} = 5'h0;
  end
  // one-cycle write; reserved places are never disturbed by this host
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h0c || a == 8'h0d) return;
    @(negedge i_clock);
    o_addr = a;
    o_wdata = (a == 8'h0e) ? (d & 8'hef) : d;
    o_write = 1'b1;
    @(negedge i_clock);
    o_write = 1'b0;
    o_wdata = ~o_wdata; // released data no longer shows the last value
  endtask
  // one-cycle read; data is taken once the sampling edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_addr = a;
    o_read = 1'b1;
    @(negedge i_clock);
    o_read = 1'b0;
    d = i_rdata;
  endtask
  // levels as {standby, uv, fault, light, pin}
  task automatic pins(input logic [4:0] v);
    @(negedge i_clock);
    {o_standby, o_uv, o_fault, o_light, o_pin} = v;
  endtask
endmodule

// ---- tb/cesq_top_sva.sv ----
// concurrent checks on the converter enable sequencer ports
// assumes the control registers change only through the byte port
`timescale 1ns/1ps
module cesq_top_sva (
  input wire i_clock,
  input wire i_resetn,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_write,
  input wire i_reg_read,
  input wire [7:0] o_reg_rdata,
  input wire i_standby_off_state,
  input wire o_converter_run,
  input wire o_softstart_active,
  input wire o_softstart_long,
  input wire o_lightload_latched,
  input wire [10:0] o_undervolt_offset_mv,
  input wire [8:0] o_cable_comp_mv,
  input wire o_status_out,
  input wire o_status_oe
);
  reg [7:0] en_q;
  reg [7:0] cf_q;
  // shadow of both control registers so outputs can be tied to their settings
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q <= 8'ha2;
      cf_q <= 8'he8;
    end else if (i_reg_write && i_reg_addr == 8'h0e) begin
      en_q <= i_reg_wdata;
    end else if (i_reg_write && i_reg_addr == 8'h0f) begin
      cf_q <= i_reg_wdata;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_soft; o_converter_run && o_softstart_active; endsequence
  sequence s_run; o_converter_run && !o_softstart_active; endsequence
  // the decoded outputs lag the register by a cycle, so only settled settings are compared
  permit_gate_a: assert property (!en_q[7] |=> !o_converter_run)
    else $error("converter runs with permit clear");
  standby_gate_a: assert property (i_standby_off_state |=> !o_converter_run)
    else $error("converter runs in standby-off");
  soft_first_a: assert property ($rose(o_converter_run) |-> s_soft)
    else $error("start skipped the soft-start ramp");
  no_resoft_a: assert property (s_run |=> not s_soft)
    else $error("ramp restarted without turning off");
  ss_select_a: assert property ($past(i_resetn) && $stable(en_q[5])
    |-> o_softstart_long == en_q[5]) else $error("ramp length select wrong");
  uv_offset_a: assert property ($past(i_resetn) && $stable(cf_q)
    |-> o_undervolt_offset_mv == cf_q[7:5] * 11'd200) else $error("uv offset wrong");
  cable_comp_a: assert property ($past(i_resetn) && $stable(cf_q)
    |-> o_cable_comp_mv == cf_q[3:2] * 9'd100) else $error("cable comp wrong");
  status_gate_a: assert property ($past(i_resetn) && !cf_q[4] && !$past(cf_q[4])
    |-> !o_status_oe) else $error("status pin pulled while disabled");
  status_low_a: assert property (o_status_out == 1'b0)
    else $error("status pin drives high");
  latch_armed_a: assert property ($rose(o_lightload_latched)
    |-> $past(en_q[0]) && $past(en_q[3:2]) != 2'b00) else $error("latch while unarmed");
  latch_off_a: assert property (o_lightload_latched |-> !o_converter_run)
    else $error("converter runs while latched off");
  unmapped_read_a: assert property (i_reg_read && (i_reg_addr < 8'h0c || i_reg_addr > 8'h0f)
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind cesq_top cesq_top_sva u_sva (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
  .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .i_standby_off_state(i_standby_off_state),
  .o_converter_run(o_converter_run), .o_softstart_active(o_softstart_active),
  .o_softstart_long(o_softstart_long), .o_lightload_latched(o_lightload_latched),
  .o_undervolt_offset_mv(o_undervolt_offset_mv), .o_cable_comp_mv(o_cable_comp_mv),
  .o_status_out(o_status_out), .o_status_oe(o_status_oe));

// ---- tb/tb.sv ----
// self-checking bench for the converter enable sequencer, shortened timing counts
// assumes the host model in cesq_host drives every input of the block except the clock and reset
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, pin, ll, flt, uv, sb, run, ss, ssl, lat, oe, so;
  wire [10:0] uvmv;
  wire [8:0] ccmv;
  int n_fail = 0;
  int checked = 0;
  int i, k, n, lim;
  logic [7:0] d, e;
  logic pol;
  logic [4:0] v;
  logic [7:0] ra [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h20};
  logic [7:0] re [5] = '{8'h10, 8'h08, 8'ha2, 8'he8, 8'h00};
  always #50 clk = ~clk;
  cesq_host host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_write(wr), .o_read(rd), .o_pin(pin), .o_light(ll), .o_fault(flt), .o_uv(uv),
    .o_standby(sb));
  // short counts keep every interval a few dozen cycles
  cesq_top #(.SS_SHORT_CYC(20), .SS_LONG_CYC(40), .ON_DLY1_CYC(10), .ON_DLY2_CYC(20),
    .ON_DLY3_CYC(30), .OFF_DLY1_CYC(50), .OFF_DLY2_CYC(60), .OFF_DLY3_CYC(70)) dut (
    .i_clock(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .i_enable_pin(pin),
    .i_light_load(ll), .i_output_fault(flt), .i_input_undervolt(uv),
    .i_standby_off_state(sb), .o_converter_run(run), .o_softstart_active(ss),
    .o_softstart_long(ssl), .o_lightload_latched(lat), .o_undervolt_offset_mv(uvmv),
    .o_cable_comp_mv(ccmv), .o_status_out(so), .o_status_oe(oe));
  task automatic give_verdict;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, x, s);
    end
  endtask
  function logic sig(input int m);
    return m == 0 ? run : m == 1 ? ss : m == 2 ? lat : oe;
  endfunction
  // counts falling edges until the chosen output reaches v; a spent bound ends the run
  task automatic waitv(input int m, input logic v, input int b, output int c);
    c = 0;
    while (sig(m) !== v && c < b) begin
      @(negedge clk);
      c++;
    end
    if (c >= b) begin
      n_fail++;
      $display("MISMATCH wait bound expected %0d seen %0d", b, c);
      give_verdict;
    end
  endtask
  task automatic stay(input int m, input logic v, input int len);
    repeat (len) begin
      @(negedge clk);
      chk("held level", v, sig(m));
    end
  endtask
  function int on_cyc(input int c); return c * 10; endfunction
  function int off_cyc(input int c); return 40 + c * 10; endfunction
  // run level once settled with delay code 00: permit, no standby, bypass or active pin level
  function logic run_exp(input logic [7:0] en, input logic [4:0] lv);
    return en[7] && !lv[4] && (en[6] || lv[0] == en[1]);
  endfunction
  initial begin
    i = $urandom(32'ha11a9ce6);
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    for (i = 0; i < 5; i++) begin
      host.rd(ra[i], d);
      chk("reset value", re[i], d);
    end
    // corner settings first, then random ones
    for (i = 0; i < 8; i++) begin
      e = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
      host.wr(8'h0f, e);
      host.rd(8'h0f, d);
      chk("config readback", e, d);
      chk("uv offset", e[7:5] * 200, uvmv);
      chk("cable comp", e[3:2] * 100, ccmv);
    end
    // random enable settings and random pin levels; light-load shutoff kept unarmed
    for (i = 0; i < 24; i++) begin
      e = 8'($urandom) & 8'hfc;
      d = 8'($urandom) & 8'hee;
      v = 5'($urandom);
      host.wr(8'h0f, e);
      host.wr(8'h0e, d);
      host.pins(v);
      repeat (6) @(negedge clk);
      chk("random run", run_exp(d, v), run);
      chk("random status", e[4] && run_exp(d, v) && !v[2] && !v[3], oe);
    end
    // every turn-on delay with both ramps and both pin polarities
    for (i = 0; i < 8; i++) begin
      k = i / 2;
      pol = i[0] ^ k[0];
      host.wr(8'h0e, 8'h00);
      host.pins({4'h0, ~pol});
      host.wr(8'h0f, {6'h00, k[1:0]});
      host.wr(8'h0e, {2'b10, i[0], 3'b000, pol, 1'b0});
      stay(0, 0, 3);
      host.pins({4'h0, pol});
      waitv(0, 1, 200, n);
      chk("turn-on cycles", 4 + on_cyc(k), n);
      chk("ramp select", i[0], ssl);
      waitv(1, 0, 200, n);
      chk("ramp cycles", (i[0] ? 40 : 20) + 1, n);
      chk("running", 1, run);
      host.pins({4'h0, ~pol});
      waitv(0, 0, 10, n);
      chk("pin release cycles", 3, n);
    end
    host.wr(8'h0f, 8'h10);
    host.wr(8'h0e, 8'h42);
    host.pins(5'h01);
    stay(0, 0, 30);
    host.wr(8'h0e, 8'hc2);
    host.pins(5'h00);
    waitv(0, 1, 10, n);
    waitv(3, 1, 40, n);
    for (i = 0; i < 2; i++) begin
      host.pins(i == 0 ? 5'h04 : 5'h08);
      waitv(3, 0, 6, n);
      host.pins(5'h00);
      waitv(3, 1, 6, n);
    end
    host.pins(5'h10);
    waitv(0, 0, 4, n);
    chk("standby off cycles", 1, n);
    host.wr(8'h0f, 8'h00);
    host.pins(5'h00);
    stay(3, 0, 30);
    // light-load latch for delay codes 01 to 11 and no latch for 00, with an early dip that must restart the timer
    for (k = 0; k < 4; k++) begin
      host.wr(8'h0e, 8'h00);
      host.wr(8'h0e, {6'b110000 | 6'(k), 2'b11});
      waitv(0, 1, 10, n);
      waitv(1, 0, 40, n);
      host.pins(5'h02);
      repeat (20) @(negedge clk);
      host.pins(5'h00);
      host.pins(5'h02);
      if (k == 0) begin
        stay(2, 0, 90);
      end else begin
        lim = off_cyc(k);
        waitv(2, 1, lim + 20, n);
        chk("latch window", 1, n >= lim && n <= lim + 5);
        host.pins(5'h00);
        stay(0, 0, 10);
        host.wr(8'h0e, 8'h00);
        host.wr(8'h0e, 8'hc2);
        waitv(0, 1, 10, n);
      end
    end
    give_verdict;
  end
endmodule
